// file: logic/sir_consts.svh
/*
 * Constants of the status and event flag register: address, bit positions,
 * reset values and timing figures.
 * Assumes a 25 MHz block clock; included by bare name.
 */
`ifndef SIR_CONSTS_SVH
`define SIR_CONSTS_SVH

// register address
`define SIR_ADDR_STATUS 8'h3A

// bit positions
`define SIR_BIT_LED_DONE 7
`define SIR_BIT_MASK_BUSY 6
`define SIR_BIT_STARTUP_BUSY 5
`define SIR_BIT_ENGINE_BUSY 4
`define SIR_BIT_EXT_TB 3
`define SIR_BIT_SEQ1 2
`define SIR_BIT_SEQ2 1
`define SIR_BIT_SEQ3 0

// reset values
`define SIR_RST_MASK_BUSY 1'h1
`define SIR_RST_BYTE 8'h00
`define SIR_RST_FLAGS 3'h0

// clock selection codes
`define SIR_CSEL_FORCED_EXT 2'h0
`define SIR_CSEL_FORCED_INT 2'h1
`define SIR_CSEL_AUTO 2'h2
`define SIR_CSEL_INT 2'h3

// timing
`define SIR_CLK_KHZ 25000
`define SIR_LED_CHECK_TIME_US 2700
`define SIR_LED_CHECK_CYCLES ((`SIR_LED_CHECK_TIME_US * `SIR_CLK_KHZ) / 1000)
`define SIR_CONV_CNT_W 17
`define SIR_CONV_CNT_ONE 17'h00001
`define SIR_TB_TIMEOUT 12'hFFF
`define SIR_TB_ZERO 12'h000

`endif

// file: logic/sir_pkg.sv
/*
 * Types of the status and event flag register.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sir_pkg;

    // led check conversion sequence
    typedef enum logic {
        SIR_CONV_IDLE,
        SIR_CONV_RUN
    } sir_conv_state_t;

endpackage

// file: logic/sir_conv_timer.sv
/*
 * LED check conversion timer: a start pulse begins a conversion of a fixed
 * number of clock cycles, ending in a one-cycle done pulse.
 * Assumes start comes from logic on the same clock; restart while running
 * begins a fresh full-length conversion.
 */
`timescale 1ns/100ps
`include "sir_consts.svh"

module sir_conv_timer #(
    parameter logic [`SIR_CONV_CNT_W-1:0] CONV_CYCLES = `SIR_CONV_CNT_W'(`SIR_LED_CHECK_CYCLES)
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    output logic busy,
    output logic done
);

    sir_pkg::sir_conv_state_t state_r, state_nxt;
    logic [`SIR_CONV_CNT_W-1:0] cnt_r, cnt_nxt;
    logic done_r, done_nxt;

    // next state of the conversion counter
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        unique case (state_r)
            sir_pkg::SIR_CONV_IDLE: begin
                if (start) begin
                    state_nxt = sir_pkg::SIR_CONV_RUN;
                    cnt_nxt = CONV_CYCLES;
                end
            end
            sir_pkg::SIR_CONV_RUN: begin
                if (start) begin
                    cnt_nxt = CONV_CYCLES; // restart
                end else if (cnt_r == `SIR_CONV_CNT_ONE) begin
                    state_nxt = sir_pkg::SIR_CONV_IDLE;
                    done_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - `SIR_CONV_CNT_ONE;
                end
            end
        endcase
    end

    // register the counter
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= sir_pkg::SIR_CONV_IDLE;
            cnt_r <= '0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = (state_r == sir_pkg::SIR_CONV_RUN);
    assign done = done_r;

endmodule

// file: logic/sir_status_int.sv
/*
 * Status and event flag register with the interrupt pin logic of a
 * programmable multi-channel light driver.
 * Assumes a register port from the serial bus slave on the same clock, status
 * inputs from engines and start-up logic on the same clock, and an external
 * timebase pin that is asynchronous.
 */
// Function
// - set LED-check-complete bit 7 once the result is stored.
// - an LED check conversion lasts about 2.7 ms.
// - LED-check-complete stays set after the conversion ends.
// - every write to this register starts a new LED check.
// - mask bit 6, reset 1, blocks busy-end interrupts.
// - with mask 0, busy end raises the interrupt.
// - a read clears busy events and releases the interrupt line.
// - bit 5 is 1 while start-up runs, 0 after.
// - bit 5 reads 1 whenever device-on is 0.
// - bit 4 is 1 while any engine clears its registers.
// - bit 3 shows a detected external timebase, only when detection enabled.
// - bits 2..0 are engine 1..3 event flags, set by end/notify.
// - reading clears the engine event flags.
// - interrupt pin is active low open drain.
// - clock select 00 ext, 01 int, 10 auto, 11 int.
`timescale 1ns/100ps
`include "sir_consts.svh"

module sir_status_int #(
    parameter logic [`SIR_CONV_CNT_W-1:0] CONV_CYCLES = `SIR_CONV_CNT_W'(`SIR_LED_CHECK_CYCLES)
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic device_on,
    input wire logic startup_running,
    input wire logic [2:0] engine_clearing,
    input wire logic [2:0] seq_event,
    input wire logic [7:0] led_check_sample,
    output logic [7:0] led_check_result,
    output logic led_check_start,
    input wire logic timebase_pin,
    input wire logic timebase_detect_on,
    input wire logic [1:0] clock_select,
    output logic use_external_clock,
    input wire logic int_as_gpo,
    input wire logic int_gpo_level,
    output logic int_pin_out,
    output logic int_pin_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // access decode

    logic hit_wr, hit_rd;
    logic conv_done;

    assign hit_wr = reg_wr && (reg_addr == `SIR_ADDR_STATUS);
    assign hit_rd = reg_rd && (reg_addr == `SIR_ADDR_STATUS);

    // conversion timer, restarted by each write
    sir_conv_timer #(
        .CONV_CYCLES(CONV_CYCLES)
    ) i_sir_conv_timer (
        .clk(clk),
        .rstn(rstn),
        .start(hit_wr),
        .busy(),
        .done(conv_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // external timebase detection

    logic tb_s1_r, tb_s2_r, tb_s3_r;
    logic [11:0] tb_idle_r, tb_idle_nxt;
    logic tb_det_r, tb_det_nxt;
    logic tb_edge;

    assign tb_edge = tb_s2_r && !tb_s3_r;

    // detected while edges keep arriving within the timeout
    always_comb begin
        tb_idle_nxt = tb_idle_r;
        tb_det_nxt = tb_det_r;
        if (!timebase_detect_on) begin
            tb_idle_nxt = `SIR_TB_ZERO;
            tb_det_nxt = 1'b0;
        end else if (tb_edge) begin
            tb_idle_nxt = `SIR_TB_ZERO;
            tb_det_nxt = 1'b1;
        end else if (tb_idle_r == `SIR_TB_TIMEOUT) begin
            tb_det_nxt = 1'b0;
        end else begin
            tb_idle_nxt = tb_idle_r + 12'h001;
        end
    end

    // pin synchroniser and detector state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tb_s1_r <= 1'b0;
            tb_s2_r <= 1'b0;
            tb_s3_r <= 1'b0;
            tb_idle_r <= `SIR_TB_ZERO;
            tb_det_r <= 1'b0;
        end else begin
            tb_s1_r <= timebase_pin;
            tb_s2_r <= tb_s1_r;
            tb_s3_r <= tb_s2_r;
            tb_idle_r <= tb_idle_nxt;
            tb_det_r <= tb_det_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags

    logic startup_busy, engine_busy;
    logic startup_busy_d_r, engine_busy_d_r;
    logic busy_end;
    logic mask_busy_r, mask_busy_nxt;
    logic led_done_r, led_done_nxt;
    logic busy_evt_r, busy_evt_nxt;
    logic [2:0] seq_flag_r, seq_flag_nxt;
    logic [7:0] result_r, result_nxt;
    logic [7:0] status_byte;

    assign startup_busy = startup_running || !device_on;
    assign engine_busy = |engine_clearing;
    assign busy_end = (startup_busy_d_r && !startup_busy) || (engine_busy_d_r && !engine_busy);

    // live view of the register
    always_comb begin
        status_byte = `SIR_RST_BYTE;
        status_byte[`SIR_BIT_LED_DONE] = led_done_r;
        status_byte[`SIR_BIT_MASK_BUSY] = mask_busy_r;
        status_byte[`SIR_BIT_STARTUP_BUSY] = startup_busy;
        status_byte[`SIR_BIT_ENGINE_BUSY] = engine_busy;
        status_byte[`SIR_BIT_EXT_TB] = tb_det_r;
        status_byte[`SIR_BIT_SEQ1] = seq_flag_r[0];
        status_byte[`SIR_BIT_SEQ2] = seq_flag_r[1];
        status_byte[`SIR_BIT_SEQ3] = seq_flag_r[2];
    end

    // next values of the flags; a set wins over a clearing read
    always_comb begin
        mask_busy_nxt = mask_busy_r;
        led_done_nxt = led_done_r;
        result_nxt = result_r;
        busy_evt_nxt = busy_evt_r;
        if (hit_wr) begin
            mask_busy_nxt = reg_wdata[`SIR_BIT_MASK_BUSY];
            led_done_nxt = 1'b0; // new conversion pending
        end
        if (conv_done) begin
            result_nxt = led_check_sample;
            led_done_nxt = 1'b1;
        end
        if (hit_rd) begin
            busy_evt_nxt = 1'b0;
        end
        if (busy_end && !mask_busy_r) begin
            busy_evt_nxt = 1'b1;
        end
    end

    // per engine event flags
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_seq
            always_comb begin
                seq_flag_nxt[gi] = seq_flag_r[gi];
                if (hit_rd) begin
                    seq_flag_nxt[gi] = 1'b0;
                end
                if (seq_event[gi]) begin
                    seq_flag_nxt[gi] = 1'b1;
                end
            end
        end
    endgenerate

    // register the flags
    always_ff @(posedge clk) begin
        if (!rstn) begin
            startup_busy_d_r <= 1'b1;
            engine_busy_d_r <= 1'b0;
            mask_busy_r <= `SIR_RST_MASK_BUSY;
            led_done_r <= 1'b0;
            busy_evt_r <= 1'b0;
            seq_flag_r <= `SIR_RST_FLAGS;
            result_r <= `SIR_RST_BYTE;
        end else begin
            startup_busy_d_r <= startup_busy;
            engine_busy_d_r <= engine_busy;
            mask_busy_r <= mask_busy_nxt;
            led_done_r <= led_done_nxt;
            busy_evt_r <= busy_evt_nxt;
            seq_flag_r <= seq_flag_nxt;
            result_r <= result_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    logic [7:0] rdata_r, rdata_nxt;
    logic start_r, start_nxt;
    logic ext_clk_r, ext_clk_nxt;
    logic pin_out_r, pin_out_nxt;
    logic pin_oe_r, pin_oe_nxt;
    logic int_req;

    // host must hold off engine-touching accesses while bit 4 reads 1
    assign int_req = (|seq_flag_r) || busy_evt_r;

    // read data, start pulse, clock choice and pin drive
    always_comb begin
        rdata_nxt = hit_rd ? status_byte : rdata_r;
        start_nxt = hit_wr;
        unique case (clock_select)
            `SIR_CSEL_FORCED_EXT: ext_clk_nxt = 1'b1;
            `SIR_CSEL_FORCED_INT: ext_clk_nxt = 1'b0;
            `SIR_CSEL_AUTO: ext_clk_nxt = tb_det_r;
            `SIR_CSEL_INT: ext_clk_nxt = 1'b0;
        endcase
        if (int_as_gpo) begin
            pin_out_nxt = int_gpo_level;
            pin_oe_nxt = 1'b1;
        end else begin
            pin_out_nxt = 1'b0;
            pin_oe_nxt = int_req;
        end
    end

    // register the outputs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_r <= `SIR_RST_BYTE;
            start_r <= 1'b0;
            ext_clk_r <= 1'b0;
            pin_out_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            start_r <= start_nxt;
            ext_clk_r <= ext_clk_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign led_check_result = result_r;
    assign led_check_start = start_r;
    assign use_external_clock = ext_clk_r;
    assign int_pin_out = pin_out_r;
    assign int_pin_oe = pin_oe_r;

endmodule

// file: tb/sir_status_int_asserts.sv
/* checker for the status and event flag register.
   assumes it is bound onto sir_status_int, one clock, synchronous reset. */
`timescale 1ns/100ps
`include "sir_consts.svh"
module sir_status_int_asserts #(
    parameter logic [`SIR_CONV_CNT_W-1:0] CONV_CYCLES = `SIR_CONV_CNT_W'(`SIR_LED_CHECK_CYCLES)
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic device_on,
    input wire logic startup_running,
    input wire logic [2:0] engine_clearing,
    input wire logic [2:0] seq_event,
    input wire logic led_check_start,
    input wire logic [1:0] clock_select,
    input wire logic use_external_clock,
    input wire logic int_as_gpo,
    input wire logic int_gpo_level,
    input wire logic int_pin_out,
    input wire logic int_pin_oe
);
    logic rd_dec;
    logic wr_dec;
    logic [17:0] age_r;
    logic [17:0] age_nxt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // decoded strobes
    assign rd_dec = reg_rd && reg_addr == `SIR_ADDR_STATUS;
    assign wr_dec = reg_wr && reg_addr == `SIR_ADDR_STATUS;
    // cycles since the last write, zero before any
    always_comb begin
        age_nxt = age_r;
        if (wr_dec) begin
            age_nxt = 18'h00001;
        end else if (age_r != 18'h00000 && age_r != 18'h3FFFF) begin
            age_nxt = age_r + 18'h00001;
        end
    end
    always_ff @(posedge clk) begin
        age_r <= rstn ? age_nxt : 18'h00000;
    end
    ////////////////////////////////////////////////////////////////////////////
    AST_START: assert property (wr_dec |=> led_check_start)
        else $error("no conversion start after write");
    AST_START_CAUSE: assert property (led_check_start |-> $past(wr_dec))
        else $error("conversion start without write");
    AST_STARTUP: assert property (rd_dec |=> reg_rdata[5] == $past(startup_running || !device_on))
        else $error("start-up busy bit wrong");
    AST_ENG_BUSY: assert property (rd_dec |=> reg_rdata[4] == $past(|engine_clearing))
        else $error("engine busy bit wrong");
    AST_EVT_PIN: assert property ((seq_event != 3'h0 && !int_as_gpo) ##1 (!rd_dec && !int_as_gpo) |=> int_pin_oe)
        else $error("engine event did not pull the pin");
    AST_CLR: assert property (rd_dec && seq_event == 3'h0 ##1 seq_event == 3'h0 ##1 rd_dec |=> reg_rdata[2:0] == 3'h0)
        else $error("engine flags not cleared by read");
    AST_DONE: assert property (rd_dec |=> reg_rdata[7] == ($past(age_r) >= CONV_CYCLES + 2))
        else $error("check complete bit at wrong time");
    AST_PIN_INT: assert property ($past(rstn) && !$past(int_as_gpo) |-> !int_pin_out)
        else $error("interrupt pin driven high");
    AST_PIN_GPO: assert property ($past(rstn) && $past(int_as_gpo) |-> int_pin_oe && int_pin_out == $past(int_gpo_level))
        else $error("output pin level wrong");
    AST_CSEL: assert property ($past(rstn) && $past(clock_select) != 2'h2 |-> use_external_clock == ($past(clock_select) == 2'h0))
        else $error("clock choice wrong");
    // main scenarios reached
    cover property (wr_dec);
    cover property (rd_dec ##1 reg_rdata[7]);
    cover property (int_pin_oe && !int_as_gpo);
endmodule
bind sir_status_int sir_status_int_asserts #(.CONV_CYCLES(CONV_CYCLES)) i_sir_status_int_asserts (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .device_on(device_on), .startup_running(startup_running),
    .engine_clearing(engine_clearing), .seq_event(seq_event), .led_check_start(led_check_start),
    .clock_select(clock_select), .use_external_clock(use_external_clock),
    .int_as_gpo(int_as_gpo), .int_gpo_level(int_gpo_level), .int_pin_out(int_pin_out),
    .int_pin_oe(int_pin_oe));

// file: tb/sir_host.sv
/* host model: issues single register accesses on the block's register port.
   assumes calls start just after a rising clock edge. */
`timescale 1ns/100ps
module sir_host (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    logic busy_seen;
    // idle bus
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        busy_seen = 1'b0;
    end
    // strobe over one taking edge, then released, read data one edge later
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        q = 8'h00;
        if (busy_seen && (a == 8'h00 || (a >= 8'h37 && a <= 8'h39) ||
                (a >= 8'h4C && a <= 8'h4E))) begin
            return;
        end
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        @(posedge clk);
        #1;
        q = reg_rdata;
        if (!wr && a == 8'h3A) begin
            busy_seen = q[4];
        end
    endtask
endmodule

// file: tb/sir_status_int_bench.sv
/* self-checking bench of the status and event flag register.
   assumes the host model drives the register port; clock 25 MHz. */
`timescale 1ns/100ps
module sir_status_int_bench;
    localparam logic [16:0] CONV = 17'h00014;
    logic clk, rstn, device_on, startup_running, timebase_pin, timebase_detect_on;
    logic int_as_gpo, int_gpo_level, reg_wr, reg_rd, led_check_start, use_external_clock;
    logic int_pin_out, int_pin_oe;
    logic [1:0] clock_select;
    logic [2:0] engine_clearing, seq_event;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, led_check_sample, led_check_result, q, p;
    int fails, total_checks, cycles;
    sir_status_int #(.CONV_CYCLES(CONV)) i_sir_status_int (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .device_on(device_on),
        .startup_running(startup_running), .engine_clearing(engine_clearing),
        .seq_event(seq_event), .led_check_sample(led_check_sample),
        .led_check_result(led_check_result), .led_check_start(led_check_start),
        .timebase_pin(timebase_pin), .timebase_detect_on(timebase_detect_on),
        .clock_select(clock_select), .use_external_clock(use_external_clock),
        .int_as_gpo(int_as_gpo), .int_gpo_level(int_gpo_level), .int_pin_out(int_pin_out),
        .int_pin_oe(int_pin_oe));
    sir_host i_sir_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        i_sir_host.access(1'b0, a, 8'h00, d);
    endtask
    task automatic wr(input logic [7:0] d);
        logic [7:0] unused;
        i_sir_host.access(1'b1, 8'h3A, d, unused);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            print_verdict();
        end
    end
    // main sequence
    initial begin
        {fails, total_checks, cycles} = '0;
        {rstn, startup_running, timebase_pin, timebase_detect_on, int_as_gpo} = '0;
        {int_gpo_level, engine_clearing, seq_event} = '0;
        device_on = 1'b1;
        clock_select = 2'h1;
        led_check_sample = 8'hA5;
        tick(10);
        rstn = 1'b1;
        rd(8'h3A, q); chk("after reset", 8'h40, q);
        device_on = 1'b0; rd(8'h3A, q); chk("device off", 8'h60, q);
        device_on = 1'b1; startup_running = 1'b1; engine_clearing = 3'h4;
        rd(8'h3A, q); chk("busy bits", 8'h70, q);
        startup_running = 1'b0; engine_clearing = 3'h0; tick(5);
        chk("masked busy end", 8'h00, {7'h00, int_pin_oe});
        $display("test busy bits done");
        wr(8'h00);
        startup_running = 1'b1; tick(2); startup_running = 1'b0; tick(5);
        chk("busy end pin", 8'h02, {6'h00, int_pin_oe, int_pin_out});
        rd(8'h3A, q); tick(1); chk("read release", 8'h00, {7'h00, int_pin_oe});
        engine_clearing = 3'h1; tick(2); engine_clearing = 3'h0; tick(5);
        chk("engine end pin", 8'h01, {7'h00, int_pin_oe});
        rd(8'h3A, q); tick(1);
        for (int i = 0; i < 3; i++) begin
            seq_event = 3'(1 << i); tick(1); seq_event = 3'h0; tick(2);
            chk("flag pin", 8'h01, {7'h00, int_pin_oe});
            rd(8'h3A, q); chk("flag bit", 8'(4 >> i), q & 8'h07);
            rd(8'h3A, q); chk("flag cleared", 8'h00, q & 8'h07);
        end
        $display("test interrupt done");
        wr(8'h40); rd(8'h3A, q); chk("check pending", 8'h40, q & 8'hC0);
        tick(CONV + 4); rd(8'h3A, q); chk("check done", 8'hC0, q & 8'hC0);
        chk("check result", 8'hA5, led_check_result);
        rd(8'h3A, q); chk("done held", 8'hC0, q & 8'hC0);
        p = q; rd(8'h3B, q); chk("unmapped read", p, q);
        $display("test led check done");
        timebase_detect_on = 1'b1;
        repeat (8) begin
            timebase_pin = ~timebase_pin; tick(2);
        end
        rd(8'h3A, q); chk("timebase seen", 8'h08, q & 8'h08);
        for (int c = 0; c < 4; c++) begin
            clock_select = 2'(c); tick(2);
            chk("clock choice", {7'h00, c % 2 == 0}, {7'h00, use_external_clock});
        end
        timebase_detect_on = 1'b0; tick(3);
        rd(8'h3A, q); chk("timebase off", 8'h00, q & 8'h08);
        int_as_gpo = 1'b1;
        for (int v = 0; v < 2; v++) begin
            int_gpo_level = 1'(v); tick(2);
            chk("output pin", {6'h00, 1'b1, 1'(v)}, {6'h00, int_pin_oe, int_pin_out});
        end
        $display("test clock and pin done");
        print_verdict();
    end
endmodule
